// ### design/control_input_bank.sv
// Purpose: one synchroniser and filter per control pin
// Assumes: all pins active high, inactive when left open
// Notes:   results leave through the control input interface

`timescale 1ns/100ps

module control_input_bank
   import rsc_io_pkg::*;
#(
   parameter int unsigned NUM           = NUM_CTRL_IN,
   parameter int unsigned STABLE_CYCLES = DEBOUNCE_CYCLES
) (
   // clock and reset
   input  wire logic           i_clk,
   input  wire logic           i_arst_n,
   // raw pins
   input  wire logic [NUM-1:0] i_pins,
   // filtered results
   ctrl_in_if.bank             ctrl
);

   // one filter per pin
   for (genvar i = 0; i < NUM; i++)
   begin : g_pin
      input_debounce #(
         .STABLE_CYCLES (STABLE_CYCLES)
      ) u_debounce (
         .i_clk    (i_clk),
         .i_arst_n (i_arst_n),
         .i_pin    (i_pins[i]),
         .o_level  (ctrl.level[i]),
         .o_rise   (ctrl.rise[i])
      );
   end

endmodule // control_input_bank

// ### design/input_debounce.sv
// Purpose: synchronise one control pin and accept a new level once it settles
// Assumes: pin is asynchronous to i_clk
// Notes:   a pulse shorter than STABLE_CYCLES is ignored

`timescale 1ns/100ps

module input_debounce
   import rsc_io_pkg::*;
#(
   parameter int unsigned STABLE_CYCLES = DEBOUNCE_CYCLES
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   // raw pin
   input  wire logic i_pin,
   // filtered result
   output logic      o_level,
   output logic      o_rise
);

   localparam int unsigned CNT_W = $clog2(STABLE_CYCLES + 1);

   if (STABLE_CYCLES < 1)
   begin : g_bad_cycles
      $error("input_debounce: STABLE_CYCLES must be at least 1");
   end

   logic             sync_meta;
   logic             sync_stable;
   logic [CNT_W-1:0] count;
   logic             settled;

   // two-flop synchroniser; only the second flop is read
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         sync_meta   <= 1'b0;
         sync_stable <= 1'b0;
      end
      else
      begin
         sync_meta   <= i_pin;
         sync_stable <= sync_meta;
      end
   end

   // new level accepted after STABLE_CYCLES differing samples in a row
   assign settled = (sync_stable != o_level) && (count == CNT_W'(STABLE_CYCLES - 1));

   // run length of the differing level
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         count <= '0;
      else if ((sync_stable == o_level) || settled)
         count <= '0;
      else
         count <= count + CNT_W'(1);
   end

   // accepted level and its rise pulse
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_level <= 1'b0;
         o_rise  <= 1'b0;
      end
      else
      begin
         o_rise <= settled & sync_stable;
         if (settled)
            o_level <= sync_stable;
      end
   end

endmodule // input_debounce

// ### design/remote_status_control_io.sv
// Purpose: drives the seven status outputs and decodes the remote control pins
// Assumes: software reports instrument conditions over APB; pins are async
// Notes:   remote calibration requests take priority over local ones
//
// Overview of operation
// - health output on while no fault is present, off as soon as one exists
// - measurement valid output follows validity of the current result
// - upper-scale output on in high range of any auto range mode
// - null-calibration output on for the whole time in zero calibration
// - span-calibration output on for the whole time in span calibration
// - diagnostic output on for the whole time in diagnostic mode
// - lower-scale output on in low range of any auto range mode
// - remote zero input held active forces zero calibration, shown as remote
// - remote span input held active forces span calibration, shown as remote
// - remote low-span input forces midpoint calibration, shown as remote
//
// The implementer's own choices: register access over APB and the placing of the registers.

`timescale 1ns/100ps

module remote_status_control_io
   import rsc_io_pkg::*;
#(
   parameter int unsigned DEBOUNCE_STABLE_CYCLES = DEBOUNCE_CYCLES
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_arst_n,

   // apb slave
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [APB_ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]           i_pwdata,
   input  wire logic [3:0]            i_pstrb,
   output logic [31:0]                o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr,

   // control input pins, active high
   input  wire logic [NUM_CTRL_IN-1:0] i_ctrl_in,

   // status outputs, high means conducting
   output logic                       o_system_ok,
   output logic                       o_measurement_valid_flag,
   output logic                       o_high_range,
   output logic                       o_zero_cal,
   output logic                       o_span_cal,
   output logic                       o_diagnostic_flag,
   output logic                       o_low_range,

   // mode indication
   output logic [1:0]                 o_cal_mode,
   output logic                       o_remote_zero_indication,
   output logic                       o_remote_span_indication,
   output logic                       o_remote_midpoint_indication
);

   if (DEBOUNCE_STABLE_CYCLES < 1)
   begin : g_bad_debounce
      $error("remote_status_control_io: DEBOUNCE_STABLE_CYCLES must be >= 1");
   end

   // -------------------------------------------------------------------------
   // declarations
   // -------------------------------------------------------------------------
   logic [COND_W-1:0]  cond;
   logic [EVENT_W-1:0] events;
   cal_mode_t          cal_mode;
   cal_mode_t          next_cal_mode;
   cal_mode_t          local_cal;
   logic               cal_remote;
   logic               next_cal_remote;

   logic               fault_present;
   logic               result_valid;
   logic               auto_range;
   logic               range_high;
   logic               diag_req;

   logic               rem_zero;
   logic               rem_span;
   logic               rem_mid;

   logic               setup_phase;
   logic               access_done;
   logic               wr_en;
   logic               addr_mapped;
   logic [31:0]        next_prdata;
   logic [EVENT_W-1:0] event_clr;
   logic [31:0]        status_word;

   ctrl_in_if #(.NUM(NUM_CTRL_IN)) ctrl_in ();

   // -------------------------------------------------------------------------
   // control input conditioning
   // -------------------------------------------------------------------------

   // sync and filter
   // every pin, spares included, passes two flops and a settle filter
   control_input_bank #(
      .NUM           (NUM_CTRL_IN),
      .STABLE_CYCLES (DEBOUNCE_STABLE_CYCLES)
   ) u_ctrl_bank (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_pins   (i_ctrl_in),
      .ctrl     (ctrl_in)
   );

   // open pin inactive
   // an open input reads low through the isolator, so low means idle
   assign rem_zero = ctrl_in.level[IN_ZERO];
   assign rem_span = ctrl_in.level[IN_SPAN];
   assign rem_mid  = ctrl_in.level[IN_MID];

   // -------------------------------------------------------------------------
   // condition fields written by software
   // -------------------------------------------------------------------------

   // field split of the condition register
   assign fault_present = cond[COND_FAULT_BIT];
   assign result_valid  = cond[COND_VALID_BIT];
   assign auto_range    = cond[COND_AUTO_BIT];
   assign range_high    = cond[COND_HIGH_BIT];
   assign diag_req      = cond[COND_DIAG_BIT];
   assign local_cal     = cal_mode_t'(cond[COND_CAL_LSB +: 2]);

   // -------------------------------------------------------------------------
   // calibration mode selection
   // -------------------------------------------------------------------------

   // remote pins override software; zero wins over span, span over midpoint,
   // so two pins held at once still give one defined mode
   always_comb
   begin
      next_cal_mode   = local_cal;
      next_cal_remote = 1'b0;
      if (rem_zero)
      begin
         next_cal_mode   = CAL_ZERO;
         next_cal_remote = 1'b1;
      end
      else if (rem_span)
      begin
         next_cal_mode   = CAL_SPAN;
         next_cal_remote = 1'b1;
      end
      else if (rem_mid)
      begin
         next_cal_mode   = CAL_MIDPOINT;
         next_cal_remote = 1'b1;
      end
      // spares ignored
      // levels of inputs 3 to 5 are never looked at here
   end

   // mode register, also the mode field output
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         cal_mode   <= CAL_NONE;
         cal_remote <= 1'b0;
      end
      else
      begin
         cal_mode   <= next_cal_mode;
         cal_remote <= next_cal_remote;
      end
   end

   assign o_cal_mode = cal_mode;

   // remote tagged mode indications
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_remote_zero_indication     <= 1'b0;
         o_remote_span_indication     <= 1'b0;
         o_remote_midpoint_indication <= 1'b0;
      end
      else
      begin
         o_remote_zero_indication     <= 1'b0;
         o_remote_span_indication     <= 1'b0;
         o_remote_midpoint_indication <= 1'b0;
         if (next_cal_remote)
         begin
            case (next_cal_mode)
               CAL_ZERO:     o_remote_zero_indication     <= 1'b1;
               CAL_SPAN:     o_remote_span_indication     <= 1'b1;
               CAL_MIDPOINT: o_remote_midpoint_indication <= 1'b1;
               default:
               begin
                  o_remote_zero_indication <= 1'b0;
               end
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // status outputs
   // -------------------------------------------------------------------------

   // condition flags, one cycle after the register write
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_system_ok              <= 1'b0;
         o_measurement_valid_flag <= 1'b0;
         o_diagnostic_flag        <= 1'b0;
      end
      else
      begin
         o_system_ok              <= ~fault_present;
         o_measurement_valid_flag <= result_valid;
         o_diagnostic_flag        <= diag_req;
      end
   end

   // range flags; with auto ranging off neither is on
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_high_range <= 1'b0;
         o_low_range  <= 1'b0;
      end
      else
      begin
         o_high_range <= auto_range & range_high;
         o_low_range  <= auto_range & ~range_high;
      end
   end

   // calibration flags, in step with o_cal_mode
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_zero_cal <= 1'b0;
         o_span_cal <= 1'b0;
      end
      else
      begin
         o_zero_cal <= (next_cal_mode == CAL_ZERO);
         // span calibration
         // midpoint is a span point too, so it also lights this flag
         o_span_cal <= (next_cal_mode == CAL_SPAN) || (next_cal_mode == CAL_MIDPOINT);
      end
   end

   // -------------------------------------------------------------------------
   // apb slave
   // -------------------------------------------------------------------------

   // one wait-free access phase: pready rises in the cycle after setup
   assign setup_phase = i_psel & ~i_penable;
   assign access_done = i_psel & i_penable & o_pready;
   assign wr_en       = access_done & i_pwrite;

   // decoder for the three words
   always_comb
   begin
      case (i_paddr)
         COND_OFFSET:   addr_mapped = 1'b1;
         STATUS_OFFSET: addr_mapped = 1'b1;
         EVENT_OFFSET:  addr_mapped = 1'b1;
         default:       addr_mapped = 1'b0;
      endcase
   end

   // live status image
   always_comb
   begin
      status_word                                = '0;
      status_word[STAT_OUT_LSB + ST_OK]          = o_system_ok;
      status_word[STAT_OUT_LSB + ST_VALID]       = o_measurement_valid_flag;
      status_word[STAT_OUT_LSB + ST_HIGH]        = o_high_range;
      status_word[STAT_OUT_LSB + ST_ZERO]        = o_zero_cal;
      status_word[STAT_OUT_LSB + ST_SPAN]        = o_span_cal;
      status_word[STAT_OUT_LSB + ST_DIAG]        = o_diagnostic_flag;
      status_word[STAT_OUT_LSB + ST_LOW]         = o_low_range;
      status_word[STAT_MODE_LSB +: 2]            = cal_mode;
      status_word[STAT_REMOTE_BIT]               = cal_remote;
      status_word[STAT_IN_LSB +: NUM_CTRL_IN]    = ctrl_in.level;
   end

   // read mux; unmapped words read as zero
   always_comb
   begin
      next_prdata = '0;
      case (i_paddr)
         COND_OFFSET:   next_prdata[COND_W-1:0]  = cond;
         STATUS_OFFSET: next_prdata              = status_word;
         EVENT_OFFSET:  next_prdata[EVENT_W-1:0] = events;
         default:       next_prdata              = '0;
      endcase
   end

   // handshake flops; read data is captured at the setup edge and held
   // through the access cycle, so a mid-transfer change cannot tear it
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
      end
      else
      begin
         o_pready  <= setup_phase;
         o_pslverr <= setup_phase & ~addr_mapped;
         if (setup_phase && !i_pwrite)
            o_prdata <= next_prdata;
         else
            o_prdata <= '0;
      end
   end

   // condition register, byte lane 0 only
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cond <= COND_RESET;
      else if (wr_en && (i_paddr == COND_OFFSET) && i_pstrb[0])
         cond <= i_pwdata[COND_W-1:0];
   end

   // write-one-to-clear mask for the event register
   assign event_clr = (wr_en && (i_paddr == EVENT_OFFSET) && i_pstrb[0]) ?
                      i_pwdata[EVENT_W-1:0] : '0;

   // sticky rise events; a rise in the clearing cycle survives the clear
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         events <= EVENT_RESET;
      else
         events <= (events & ~event_clr) | ctrl_in.rise[NUM_CAL_IN-1:0];
   end

endmodule // remote_status_control_io

// ### inc/ctrl_in_if.sv
// Purpose: carries filtered control input levels and rise pulses to the core
// Assumes: both ends run on the system clock
// Notes:   level is a settled level, rise a one-cycle pulse on its rise

`timescale 1ns/100ps

interface ctrl_in_if
   import rsc_io_pkg::*;
#(
   parameter int unsigned NUM = NUM_CTRL_IN
) ();
   logic [NUM-1:0] level;
   logic [NUM-1:0] rise;

   modport bank (output level, rise);
   modport core (input  level, rise);
endinterface

// ### inc/rsc_io_pkg.sv
// Purpose: shared constants and types for the remote status/control I/O block
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes:   register offsets are byte addresses, one aligned word each

package rsc_io_pkg;

   // -------------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_MHZ     = 100;
   // settle time a control pin must hold before it counts, in microseconds
   localparam int unsigned DEBOUNCE_TIME_US = 10;
   localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;

   // -------------------------------------------------------------------------
   // control input pins: three calibration requests, three spares
   // -------------------------------------------------------------------------
   localparam int unsigned NUM_CTRL_IN = 6;
   localparam int unsigned IN_ZERO     = 0;
   localparam int unsigned IN_SPAN     = 1;
   localparam int unsigned IN_MID      = 2;
   localparam int unsigned NUM_CAL_IN  = 3;

   // -------------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------------
   localparam int unsigned APB_ADDR_W    = 8;
   localparam logic [7:0]  COND_OFFSET   = 8'h00;
   localparam logic [7:0]  STATUS_OFFSET = 8'h04;
   localparam logic [7:0]  EVENT_OFFSET  = 8'h08;

   // condition register fields (software reports instrument state)
   localparam int unsigned COND_W         = 7;
   localparam int unsigned COND_FAULT_BIT = 0;
   localparam int unsigned COND_VALID_BIT = 1;
   localparam int unsigned COND_AUTO_BIT  = 2;
   localparam int unsigned COND_HIGH_BIT  = 3;
   localparam int unsigned COND_DIAG_BIT  = 4;
   localparam int unsigned COND_CAL_LSB   = 5;
   // fault present after reset, so the health output starts released
   localparam logic [6:0]  COND_RESET     = 7'h01;

   // status register fields
   localparam int unsigned STAT_OUT_LSB    = 0;
   localparam int unsigned STAT_MODE_LSB   = 8;
   localparam int unsigned STAT_REMOTE_BIT = 10;
   localparam int unsigned STAT_IN_LSB     = 16;

   // status output bit order inside the status field
   localparam int unsigned NUM_STATUS = 7;
   localparam int unsigned ST_OK      = 0;
   localparam int unsigned ST_VALID   = 1;
   localparam int unsigned ST_HIGH    = 2;
   localparam int unsigned ST_ZERO    = 3;
   localparam int unsigned ST_SPAN    = 4;
   localparam int unsigned ST_DIAG    = 5;
   localparam int unsigned ST_LOW     = 6;

   // sticky event register: one bit per calibration input rising
   localparam int unsigned EVENT_W     = 3;
   localparam logic [2:0]  EVENT_RESET = 3'h0;

   // calibration mode of the instrument
   typedef enum logic [1:0] {
      CAL_NONE,
      CAL_ZERO,
      CAL_SPAN,
      CAL_MIDPOINT
   } cal_mode_t;

endpackage

// ### verification/plc_receiver.sv
// Purpose: far side that closes contacts onto the control pins
// Assumes: pins active high
// Notes:   status outputs are judged by the bench
`timescale 1ns/100ps
module plc_receiver
(
   // clock
   input  wire logic       i_clk,
   // contacts closed to the pull-up supply
   input  wire logic [5:0] i_closed,
   // control pins
   output logic      [5:0] o_pins
);
   // closed contact drives high
   // an open contact reads inactive, never floating
   initial o_pins = 6'h0;
   always @(posedge i_clk)
      o_pins <= i_closed;
endmodule // plc_receiver

// ### verification/remote_status_control_io_tb.sv
// Purpose: self-checking bench for remote_status_control_io
// Assumes: debounce shortened to 4 cycles
// Notes:   random cond values from an lfsr seeded 32'h4450
`timescale 1ns/100ps
`define CHK(a, b) \
   begin \
      num_checks++; \
      if ((a) !== (b)) \
      begin \
         n_fail++; \
         $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); \
      end \
   end
module remote_status_control_io_tb
   import rsc_io_pkg::*;
();
   localparam int unsigned N = 4;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [5:0]  closed = 6'h0;
   logic [31:0] d, lf;
   logic [6:0]  c;
   logic        e;
   wire  [31:0] prdata;
   wire         pready, pslverr;
   wire  [5:0]  pins;
   wire  [6:0]  st;
   wire  [1:0]  mode;
   wire  [2:0]  ind;
   int          n_fail = 0;
   int          num_checks = 0;
   logic [5:0]  pv [7] = '{6'h01, 6'h02, 6'h04, 6'h07, 6'h06, 6'h38, 6'h0};

   always #5 clk = ~clk;

   plc_receiver far (.i_clk(clk), .i_closed(closed), .o_pins(pins));
   remote_status_control_io #(.DEBOUNCE_STABLE_CYCLES(N)) dut (
      .i_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ctrl_in(pins),
      .o_system_ok(st[0]), .o_measurement_valid_flag(st[1]), .o_high_range(st[2]),
      .o_zero_cal(st[3]), .o_span_cal(st[4]), .o_diagnostic_flag(st[5]),
      .o_low_range(st[6]), .o_cal_mode(mode), .o_remote_zero_indication(ind[0]),
      .o_remote_span_indication(ind[1]), .o_remote_midpoint_indication(ind[2]));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // expected {indications, mode, outputs}; zero beats span beats midpoint
   function automatic logic [11:0] expect_io(input logic [6:0] k, input logic [5:0] p);
      logic [1:0] m;
      logic [2:0] r;
      m = p[0] ? 2'h1 : p[1] ? 2'h2 : p[2] ? 2'h3 : k[6:5];
      r = (|p[2:0]) ? 3'h1 << (m - 2'h1) : 3'h0;
      return {r, m, k[2] & ~k[3], k[4], m[1], m == 2'h1, k[2] & k[3], k[1], ~k[0]};
   endfunction
   // one apb transfer; waits on pready, bounded by the count
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20)
         n_fail++;
      // answer taken at the completing edge
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v, 4'hf, d, e);
      `CHK(e, 1'b0)
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'hf, d, e);
   endtask
   // ports and status word against the model
   task automatic check_all(input logic [6:0] k, input logic [5:0] p);
      logic [11:0] x;
      x = expect_io(k, p);
      @(posedge clk);
      @(negedge clk);
      `CHK({ind, mode, st}, x)
      rd(STATUS_OFFSET);
      `CHK({d[21:16], d[10:0]}, {p, |x[11:9], x[8:7], 1'b0, x[6:0]})
   endtask
   task automatic final_report();
      if (n_fail == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // watchdog, far beyond the few hundred cycles needed
   initial
   begin
      #200000;
      n_fail++;
      final_report();
   end

   initial
   begin
      lf = 32'h4450;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd(COND_OFFSET);
      `CHK(d[6:0], COND_RESET)
      check_all(7'h01, 6'h0);
      // random conditions through every local mode
      for (int i = 0; i < 16; i++)
      begin
         lf = lfsr(lf);
         c = (i == 15) ? 7'h00 : {i[1:0], lf[4:0]};
         wr(COND_OFFSET, {lf[31:7], c});
         check_all(c, 6'h0);
      end
      // remote requests, priority, spares, then release
      for (int j = 0; j < 7; j++)
      begin
         lf = lfsr(lf);
         closed <= (j == 6) ? lf[5:0] : pv[j];
         repeat (N + 8) @(posedge clk);
         check_all(c, closed);
         closed <= 6'h0;
         repeat (N + 8) @(posedge clk);
         check_all(c, 6'h0);
      end
      rd(EVENT_OFFSET);
      `CHK(d[2:0], 3'h7)
      wr(EVENT_OFFSET, 32'h7);
      // a pulse shorter than the filter leaves no trace
      closed <= 6'h01;
      repeat (2) @(posedge clk);
      closed <= 6'h0;
      repeat (N + 8) @(posedge clk);
      check_all(c, 6'h0);
      rd(EVENT_OFFSET);
      `CHK(d[2:0], 3'h0)
      // unmapped read and write, status write, unstrobed write
      apb(1'b0, 8'h0c, 32'h0, 4'hf, d, e);
      `CHK({e, d}, {1'b1, 32'h0})
      apb(1'b1, 8'h0c, 32'h7f, 4'hf, d, e);
      `CHK(e, 1'b1)
      wr(STATUS_OFFSET, 32'hffffffff);
      apb(1'b1, COND_OFFSET, {25'h0, ~c}, 4'h0, d, e);
      check_all(c, 6'h0);
      final_report();
   end
endmodule // remote_status_control_io_tb

// ### verification/rsc_io_props.sv
// Purpose: port checker for remote_status_control_io
// Assumes: one clock, async active-low reset
// Notes:   cond shadow is rebuilt from completed apb writes
`timescale 1ns/100ps
module rsc_io_props
   import rsc_io_pkg::*;
#(parameter int unsigned DEBOUNCE_STABLE_CYCLES = DEBOUNCE_CYCLES)
(
   // clock and reset
   input wire logic                   i_clk,
   input wire logic                   i_arst_n,
   // apb
   input wire logic                   i_psel,
   input wire logic                   i_penable,
   input wire logic                   i_pwrite,
   input wire logic [APB_ADDR_W-1:0]  i_paddr,
   input wire logic [31:0]            i_pwdata,
   input wire logic [3:0]             i_pstrb,
   input wire logic [31:0]            o_prdata,
   input wire logic                   o_pready,
   input wire logic                   o_pslverr,
   // pins and outputs
   input wire logic [NUM_CTRL_IN-1:0] i_ctrl_in,
   input wire logic                   o_system_ok,
   input wire logic                   o_measurement_valid_flag,
   input wire logic                   o_high_range,
   input wire logic                   o_zero_cal,
   input wire logic                   o_span_cal,
   input wire logic                   o_diagnostic_flag,
   input wire logic                   o_low_range,
   input wire logic [1:0]             o_cal_mode,
   input wire logic                   o_remote_zero_indication,
   input wire logic                   o_remote_span_indication,
   input wire logic                   o_remote_midpoint_indication
);
   localparam int LAT_MAX = DEBOUNCE_STABLE_CYCLES;
   logic [6:0] cond;
   // shadow of cond; only a completed, strobed access counts
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         cond <= COND_RESET;
      else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == COND_OFFSET
               && i_pstrb[0])
         cond <= i_pwdata[6:0];
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   // health from fault
   a_health_no_fault: assert property (o_system_ok == !$past(cond[0]))
      else $error("health output wrong");
   a_valid_follows: assert property (o_measurement_valid_flag == $past(cond[1]))
      else $error("valid output wrong");
   a_high_range: assert property (o_high_range == ($past(cond[2]) && $past(cond[3])))
      else $error("high range output wrong");
   a_low_range: assert property (o_low_range == ($past(cond[2]) && !$past(cond[3])))
      else $error("low range output wrong");
   a_diag_follows: assert property (o_diagnostic_flag == $past(cond[4]))
      else $error("diagnostic output wrong");
   a_zero_mode: assert property (o_zero_cal == (o_cal_mode == 2'h1))
      else $error("zero output wrong");
   a_span_mode: assert property (o_span_cal == o_cal_mode[1])
      else $error("span output wrong");
   a_remote_zero: assert property ($rose(i_ctrl_in[0]) ##1 i_ctrl_in[0] [*8] |->
      ##[0:LAT_MAX] (o_remote_zero_indication && o_cal_mode == 2'h1))
      else $error("remote zero not entered");
   a_remote_span: assert property (o_remote_span_indication |->
      o_cal_mode == 2'h2 && !o_remote_zero_indication) else $error("span mode wrong");
   a_remote_mid: assert property (o_remote_midpoint_indication |-> o_cal_mode == 2'h3)
      else $error("midpoint mode wrong");
   a_filter_hold: assert property ($rose(o_remote_zero_indication) |->
      $past(i_ctrl_in[0], 5)) else $error("short pin pulse accepted");
   a_ready_pulse: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
      else $error("pready not a one-cycle answer");
   a_err_ready: assert property (o_pslverr |-> o_pready) else $error("pslverr alone");
   c_remote_zero: cover property (o_remote_zero_indication);
   c_error: cover property (o_pslverr);
   c_high: cover property (o_high_range && o_span_cal);
endmodule // rsc_io_props
bind remote_status_control_io rsc_io_props
   #(.DEBOUNCE_STABLE_CYCLES(DEBOUNCE_STABLE_CYCLES)) u_props (.*);
